// ---- adc_link_asserts.sv ----
// protocol checks on the converter read link
`timescale 1ns/1ps
`default_nettype none
module adc_link_asserts (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // link wires
  input wire logic i_scl,
  input wire logic i_host_sda_o,
  input wire logic i_host_sda_oe,
  input wire logic i_dev_sda_o,
  input wire logic i_dev_sda_oe,
  input wire logic i_sda
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  open_drain_a: assert property (!i_host_sda_o && !i_dev_sda_o)
    else $error("sda driven high");
  dev_low_edge_a: assert property ($changed(i_dev_sda_oe) |-> !i_scl)
    else $error("device moved sda with scl high");
  no_contention_a: assert property (i_scl |-> !(i_host_sda_oe && i_dev_sda_oe))
    else $error("both ends pull sda during a bit");
  start_by_host_a: assert property (i_scl && $past(i_scl) && $fell(i_sda) |-> !i_dev_sda_oe)
    else $error("device made a start");
  stop_quiet_a: assert property (i_scl && $past(i_scl) && $rose(i_sda) |=> !i_dev_sda_oe [*8])
    else $error("device drives after stop");
  scl_high_a: assert property ($rose(i_scl) |-> i_scl [*4])
    else $error("scl high too short");
  scl_low_a: assert property ($fell(i_scl) |-> !i_scl [*4])
    else $error("scl low too short");
  idle_reset_a: assert property ($fell(i_reset) |-> i_scl && !i_host_sda_oe && !i_dev_sda_oe)
    else $error("link not idle after reset");

  cover property (i_scl && $past(i_scl) && $fell(i_sda));
  cover property (i_scl && $past(i_scl) && $rose(i_sda));
  cover property ($rose(i_dev_sda_oe));
  // stretched high phase after a ninth rise
  cover property ($rose(i_scl) ##1 i_scl [*8] ##1 i_scl [*8]);
endmodule
`default_nettype wire

// ---- adc_link_device.sv ----
// converter end: read sequencing, result framing and power control
//
// Summary of operation
// R01 - every result read is exactly two bytes
// R02 - keep supplying results while master keeps reading
// R03 - acknowledge own address with read bit
// R04 - four status bits: two zeros, channel tag
// R05 - first byte: status then four top bits
// R06 - second byte: low bits, trailing zeros per variant
// R07 - wake and acquire at ninth rising edge
// R08 - after acquisition time sample and start converting
// R09 - master ack on second byte: convert again
// R10 - master nack on second byte: no conversion
// R11 - stop condition puts device into full shutdown
// R12 - never acknowledge the high speed master code
// R13 - repeated start then address is acknowledged
// R14 - high speed mode holds until stop
// R15 - master stretches clock two microseconds when fast; the host stretches whenever i_stretch is set, at any speed
// R16 - power up in shutdown, wake on address
// R17 - all channels enabled by default
// R18 - ack advances to next enabled channel
// R19 - ascending order from lowest, zero selects none
// R20 - word: two zeros, tag, result msb first
// R21 - drive data while clock low, release ack
`timescale 1ns/1ps
`include "adc_link_map.svh"
`default_nettype none
module adc_link_device #(
  parameter int RESOLUTION = 12
) (
  // core clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_clk_en,
  // two-wire link
  adc_link_if.device                link,
  // converter side
  input  wire logic [11:0]          i_result,
  input  wire logic                 i_result_valid,
  input  wire logic [3:0]           i_channel_enable,
  input  wire logic                 i_channel_load,
  output logic                      o_shutdown,
  output logic                      o_high_speed,
  output logic                      o_acquire,
  output logic                      o_convert_start,
  output adc_link_pkg::channel_t    o_channel
);
  import adc_link_pkg::*;

  localparam logic [11:0] RES_MASK = 12'(12'hFFF << (`ADC_RESULT_BITS - RESOLUTION));
  localparam logic [4:0]  ACQ_LAST = 5'(`ADC_ACQ_CYCLES - 1);

  function automatic channel_t pick_channel(input logic [3:0] en, input channel_t cur, input logic first);
    channel_t base;
    channel_t idx;
    channel_t sel;
    logic     hit;
    base = first ? 2'h3 : cur;
    sel  = cur;
    hit  = 1'b0;
    for (int k = 1; k <= 4; k++) begin
      idx = 2'(base + 2'(k));
      if (en[idx] && !hit) begin // R19
        sel = idx;
        hit = 1'b1;
      end
    end
    return sel;
  endfunction

  // start and stop markers, clocked by the data line itself
  logic start_tgl_reg;
  logic start_tgl_next;
  logic stop_tgl_reg;
  logic stop_tgl_next;

  always_comb begin
    start_tgl_next = link.scl ? !start_tgl_reg : start_tgl_reg;
    stop_tgl_next  = link.scl ? !stop_tgl_reg : stop_tgl_reg;
  end

  always_ff @(negedge link.sda or posedge i_reset) begin
    if (i_reset) begin
      start_tgl_reg <= 1'b0;
    end else begin
      start_tgl_reg <= start_tgl_next;
    end
  end

  always_ff @(posedge link.sda or posedge i_reset) begin
    if (i_reset) begin
      stop_tgl_reg <= 1'b0;
    end else begin
      stop_tgl_reg <= stop_tgl_next;
    end
  end

  // link domain, sampled on rising scl
  dev_state_e   state_reg;
  dev_state_e   state_next;
  logic [3:0]   bit_reg;
  logic [3:0]   bit_next;
  logic [7:0]   shift_reg;
  logic [7:0]   shift_next;
  logic         start_ack_reg;
  logic         start_ack_next;
  logic         wake_tgl_reg;
  logic         wake_tgl_next;
  logic         hs_tgl_reg;
  logic         hs_tgl_next;
  result_word_t word_reg;
  result_word_t word_next;
  logic         res_s1_reg;
  logic         res_s2_reg;
  logic         res_ack_reg;
  logic         res_ack_next;
  logic         load_word;
  logic         addr_match;
  logic         is_master_code;

  // core-side result hold, read only after its toggle crossed
  logic [11:0]  result_reg;
  logic [11:0]  result_next;
  channel_t     tag_reg;
  channel_t     tag_next;
  logic         res_tgl_reg;
  logic         res_tgl_next;

  assign addr_match     = (shift_reg == {`ADC_DEV_ADDR, `ADC_READ_BIT}); // R03
  assign is_master_code = (shift_reg[7:3] == `ADC_MASTER_CODE_TOP);

  always_comb begin
    state_next     = state_reg;
    bit_next       = bit_reg;
    shift_next     = shift_reg;
    start_ack_next = start_ack_reg;
    wake_tgl_next  = wake_tgl_reg;
    hs_tgl_next    = hs_tgl_reg;
    word_next      = word_reg;
    res_ack_next   = res_ack_reg;
    load_word      = 1'b0;
    if (start_tgl_reg != start_ack_reg) begin
      // first address bit follows a start or repeated start
      start_ack_next = start_tgl_reg; // R13
      state_next     = DEV_ADDR;
      shift_next     = {7'h00, link.sda};
      bit_next       = 4'h1;
    end else begin
      case (state_reg)
        DEV_ADDR: begin
          if (bit_reg != `ADC_BYTE_BITS) begin
            shift_next = {shift_reg[6:0], link.sda};
            bit_next   = bit_reg + 4'h1;
          end else begin
            bit_next = 4'h0;
            if (addr_match) begin
              state_next    = DEV_READ_HI;
              wake_tgl_next = !wake_tgl_reg; // R07 R16
              load_word     = 1'b1;
            end else begin
              state_next = DEV_IDLE;
              if (is_master_code) begin
                hs_tgl_next = !hs_tgl_reg; // R12
              end
            end
          end
        end
        DEV_READ_HI: begin
          if (bit_reg != `ADC_BYTE_BITS) begin
            bit_next = bit_reg + 4'h1;
          end else begin
            // master ack on first byte ignored: a result is two bytes
            bit_next   = 4'h0;
            state_next = DEV_READ_LO; // R01
          end
        end
        DEV_READ_LO: begin
          if (bit_reg != `ADC_BYTE_BITS) begin
            bit_next = bit_reg + 4'h1;
          end else begin
            bit_next = 4'h0;
            if (!link.sda) begin
              state_next    = DEV_READ_HI; // R02
              wake_tgl_next = !wake_tgl_reg; // R09
              load_word     = 1'b1;
            end else begin
              state_next = DEV_IDLE; // R10
            end
          end
        end
        default: begin
          state_next = DEV_IDLE;
        end
      endcase
    end
    if (load_word && (res_s2_reg != res_ack_reg)) begin
      word_next    = {`ADC_LEAD_ZEROS, tag_reg, result_reg & RES_MASK}; // R04 R05 R06 R20
      res_ack_next = res_s2_reg;
    end
  end

  always_ff @(posedge link.scl or posedge i_reset) begin
    if (i_reset) begin
      state_reg     <= DEV_IDLE;
      bit_reg       <= 4'h0;
      shift_reg     <= 8'h00;
      start_ack_reg <= 1'b0;
      wake_tgl_reg  <= 1'b0;
      hs_tgl_reg    <= 1'b0;
      word_reg      <= 16'h0000;
      res_s1_reg    <= 1'b0;
      res_s2_reg    <= 1'b0;
      res_ack_reg   <= 1'b0;
    end else begin
      state_reg     <= state_next;
      bit_reg       <= bit_next;
      shift_reg     <= shift_next;
      start_ack_reg <= start_ack_next;
      wake_tgl_reg  <= wake_tgl_next;
      hs_tgl_reg    <= hs_tgl_next;
      word_reg      <= word_next;
      res_s1_reg    <= res_tgl_reg;
      res_s2_reg    <= res_s1_reg;
      res_ack_reg   <= res_ack_next;
    end
  end

  // data line driven on falling scl only
  logic       oe_reg;
  logic       oe_next;
  logic [7:0] byte_sel;

  always_comb begin
    byte_sel = (state_reg == DEV_READ_HI) ? word_reg[15:8] : word_reg[7:0];
    oe_next  = 1'b0;
    if (start_tgl_reg == start_ack_reg) begin
      case (state_reg)
        DEV_ADDR: begin
          oe_next = (bit_reg == `ADC_BYTE_BITS) && addr_match; // R03 R12
        end
        DEV_READ_HI, DEV_READ_LO: begin
          oe_next = (bit_reg != `ADC_BYTE_BITS) && !byte_sel[3'h7 - bit_reg[2:0]]; // R21
        end
        default: begin
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(negedge link.scl or posedge i_reset) begin
    if (i_reset) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= oe_next;
    end
  end

  assign link.dev_sda_oe = oe_reg;
  assign link.dev_sda_o  = 1'b0;

  // core domain: power, acquisition timing, channel sequence
  logic [2:0] evt_tgl;
  logic [2:0] evt_s1_reg;
  logic [2:0] evt_s2_reg;
  logic [2:0] evt_seen_reg;
  logic [2:0] evt_pulse;
  logic       shutdown_reg;
  logic       shutdown_next;
  logic       high_speed_reg;
  logic       high_speed_next;
  logic       acquire_reg;
  logic       acquire_next;
  logic       convert_reg;
  logic       convert_next;
  logic [4:0] acq_cnt_reg;
  logic [4:0] acq_cnt_next;
  channel_t   channel_reg;
  channel_t   channel_next;
  logic       first_reg;
  logic       first_next;
  logic [3:0] chan_en_reg;
  logic [3:0] chan_en_next;

  assign evt_tgl   = {stop_tgl_reg, hs_tgl_reg, wake_tgl_reg};
  assign evt_pulse = evt_s2_reg ^ evt_seen_reg;

  always_comb begin
    shutdown_next   = shutdown_reg;
    high_speed_next = high_speed_reg;
    acquire_next    = acquire_reg;
    convert_next    = 1'b0;
    acq_cnt_next    = acq_cnt_reg;
    channel_next    = channel_reg;
    first_next      = first_reg;
    chan_en_next    = chan_en_reg;
    result_next     = result_reg;
    tag_next        = tag_reg;
    res_tgl_next    = res_tgl_reg;
    if (acquire_reg) begin
      if (acq_cnt_reg == ACQ_LAST) begin
        acquire_next = 1'b0;
        convert_next = 1'b1; // R08
      end else begin
        acq_cnt_next = acq_cnt_reg + 5'h01;
      end
    end
    if (evt_pulse[0]) begin
      shutdown_next = 1'b0; // R16
      // no channel selected: awake but nothing to convert
      if (chan_en_reg != 4'h0) begin
        channel_next = pick_channel(chan_en_reg, channel_reg, first_reg); // R18 R19
        first_next   = 1'b0;
        acquire_next = 1'b1; // R07
        acq_cnt_next = 5'h00;
      end
    end
    if (evt_pulse[1]) begin
      high_speed_next = 1'b1; // R12
    end
    if (evt_pulse[2]) begin
      shutdown_next   = 1'b1; // R11
      high_speed_next = 1'b0; // R14
      first_next      = 1'b1;
    end
    if (i_channel_load) begin
      chan_en_next = i_channel_enable; // R17
    end
    if (i_result_valid) begin
      result_next  = i_result;
      tag_next     = channel_reg; // R20
      res_tgl_next = !res_tgl_reg;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      evt_s1_reg     <= 3'h0;
      evt_s2_reg     <= 3'h0;
      evt_seen_reg   <= 3'h0;
      shutdown_reg   <= 1'b1;
      high_speed_reg <= 1'b0;
      acquire_reg    <= 1'b0;
      convert_reg    <= 1'b0;
      acq_cnt_reg    <= 5'h00;
      channel_reg    <= 2'h0;
      first_reg      <= 1'b1;
      chan_en_reg    <= `ADC_CHAN_EN_RST;
      result_reg     <= 12'h000;
      tag_reg        <= 2'h0;
      res_tgl_reg    <= 1'b0;
    end else if (i_clk_en) begin
      evt_s1_reg     <= evt_tgl;
      evt_s2_reg     <= evt_s1_reg;
      evt_seen_reg   <= evt_s2_reg;
      shutdown_reg   <= shutdown_next;
      high_speed_reg <= high_speed_next;
      acquire_reg    <= acquire_next;
      convert_reg    <= convert_next;
      acq_cnt_reg    <= acq_cnt_next;
      channel_reg    <= channel_next;
      first_reg      <= first_next;
      chan_en_reg    <= chan_en_next;
      result_reg     <= result_next;
      tag_reg        <= tag_next;
      res_tgl_reg    <= res_tgl_next;
    end
  end

  assign o_shutdown      = shutdown_reg;
  assign o_high_speed    = high_speed_reg;
  assign o_acquire       = acquire_reg;
  assign o_convert_start = convert_reg;
  assign o_channel       = channel_reg;
endmodule
`default_nettype wire

// ---- adc_link_host.sv ----
// host end: generates scl and runs read transactions
`timescale 1ns/1ps
`include "adc_link_map.svh"
`default_nettype none
module adc_link_host (
  // core clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_clk_en,
  // two-wire link
  adc_link_if.host                  link,
  // read request
  input  wire logic                 i_start,
  input  wire logic [6:0]           i_address,
  input  wire logic [7:0]           i_count,
  input  wire logic                 i_high_speed,
  input  wire logic                 i_stretch,
  // results
  output logic                      o_busy,
  output adc_link_pkg::result_word_t o_word,
  output logic                      o_word_valid,
  output logic                      o_addr_nack
);
  import adc_link_pkg::*;

  localparam logic [2:0] QTR_LAST = 3'(`ADC_SCL_QTR_CYCLES - 1);
  localparam logic [4:0] STR_LAST = 5'(`ADC_STRETCH_CYCLES - 1);

  host_state_e  state_reg, state_next;
  logic [2:0]   qtr_reg, qtr_next;
  logic [1:0]   phase_reg, phase_next;
  logic [3:0]   bit_reg, bit_next;
  logic [7:0]   tx_reg, tx_next;
  result_word_t rx_reg, rx_next;
  logic [7:0]   remain_reg, remain_next;
  logic [6:0]   addr_reg, addr_next;
  logic [4:0]   str_reg, str_next;
  logic         scl_reg, scl_next;
  logic         oe_reg, oe_next;
  logic         hs_pend_reg, hs_pend_next;
  logic         str_en_reg, str_en_next;
  logic         lo_reg, lo_next;
  logic         ack_reg, ack_next;
  logic         busy_reg, busy_next;
  logic         valid_reg, valid_next;
  logic         nack_reg, nack_next;
  result_word_t word_reg, word_next;
  logic         sda_s1_reg, sda_s2_reg;
  logic         tick;

  assign tick = (qtr_reg == QTR_LAST);

  always_comb begin
    state_next = state_reg;
    qtr_next = (state_reg == H_IDLE || state_reg == H_STRETCH || tick) ? 3'h0 : qtr_reg + 3'h1;
    phase_next = (tick && state_reg != H_IDLE && state_reg != H_STRETCH) ? phase_reg + 2'h1 : phase_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    remain_next = remain_reg;
    addr_next = addr_reg;
    str_next = str_reg;
    scl_next = scl_reg;
    oe_next = oe_reg;
    hs_pend_next = hs_pend_reg;
    str_en_next = str_en_reg;
    lo_next = lo_reg;
    ack_next = ack_reg;
    busy_next = busy_reg;
    valid_next = 1'b0;
    nack_next = 1'b0;
    word_next = word_reg;
    case (state_reg)
      H_IDLE: begin
        scl_next = 1'b1;
        oe_next = 1'b0;
        phase_next = 2'h0;
        if (i_start) begin
          busy_next = 1'b1;
          addr_next = i_address;
          remain_next = (i_count == 8'h00) ? 8'h01 : i_count;
          str_en_next = i_stretch;
          hs_pend_next = i_high_speed;
          tx_next = i_high_speed ? `ADC_MASTER_CODE : {i_address, `ADC_READ_BIT}; // R03 R12
          state_next = H_START;
        end
      end
      H_START: if (tick) begin
        case (phase_reg)
          2'h0: begin scl_next = 1'b0; oe_next = 1'b0; end
          2'h1: scl_next = 1'b1;
          2'h2: oe_next = 1'b1;
          default: begin scl_next = 1'b0; bit_next = 4'h0; state_next = H_SEND; end
        endcase
      end
      H_SEND: if (tick) begin
        case (phase_reg)
          2'h0: oe_next = (bit_reg != `ADC_BYTE_BITS) && !tx_reg[3'h7 - bit_reg[2:0]];
          2'h1: scl_next = 1'b1;
          2'h2: if (bit_reg == `ADC_BYTE_BITS) ack_next = sda_s2_reg;
          default: begin
            bit_next = (bit_reg == `ADC_BYTE_BITS) ? 4'h0 : bit_reg + 4'h1;
            scl_next = 1'b0;
            if (bit_reg == `ADC_BYTE_BITS) begin
              lo_next = 1'b0;
              if (hs_pend_reg) begin
                hs_pend_next = 1'b0;
                tx_next = {addr_reg, `ADC_READ_BIT};
                state_next = H_START; // R13
              end else if (ack_reg) begin
                nack_next = 1'b1;
                state_next = H_STOP;
              end else if (str_en_reg) begin
                scl_next = 1'b1; // R15
                state_next = H_STRETCH;
              end else begin
                state_next = H_RECV;
              end
            end
          end
        endcase
      end
      H_RECV: if (tick) begin
        case (phase_reg)
          2'h0: oe_next = (bit_reg == `ADC_BYTE_BITS) && (!lo_reg || remain_reg != 8'h01); // R01 R09 R10
          2'h1: scl_next = 1'b1;
          2'h2: if (bit_reg != `ADC_BYTE_BITS) rx_next = {rx_reg[14:0], sda_s2_reg};
          default: begin
            bit_next = (bit_reg == `ADC_BYTE_BITS) ? 4'h0 : bit_reg + 4'h1;
            scl_next = 1'b0;
            if (bit_reg == `ADC_BYTE_BITS) begin
              lo_next = !lo_reg;
              if (lo_reg) begin
                word_next = rx_reg;
                valid_next = 1'b1;
                if (remain_reg == 8'h01) begin
                  state_next = H_STOP; // R11
                end else begin
                  remain_next = remain_reg - 8'h01;
                  if (str_en_reg) begin
                    scl_next = 1'b1; // R15
                    state_next = H_STRETCH;
                  end
                end
              end
            end
          end
        endcase
      end
      H_STRETCH: begin
        str_next = str_reg + 5'h01;
        if (str_reg == STR_LAST) begin
          str_next = 5'h00;
          scl_next = 1'b0;
          state_next = H_RECV;
        end
      end
      H_STOP: if (tick) begin
        case (phase_reg)
          2'h0: oe_next = 1'b1;
          2'h1: scl_next = 1'b1;
          2'h2: oe_next = 1'b0;
          default: begin busy_next = 1'b0; state_next = H_IDLE; end
        endcase
      end
      default: state_next = H_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= H_IDLE;
      qtr_reg <= 3'h0;
      phase_reg <= 2'h0;
      bit_reg <= 4'h0;
      tx_reg <= 8'h00;
      rx_reg <= 16'h0000;
      remain_reg <= 8'h00;
      addr_reg <= 7'h00;
      str_reg <= 5'h00;
      scl_reg <= 1'b1;
      oe_reg <= 1'b0;
      hs_pend_reg <= 1'b0;
      str_en_reg <= 1'b0;
      lo_reg <= 1'b0;
      ack_reg <= 1'b1;
      busy_reg <= 1'b0;
      valid_reg <= 1'b0;
      nack_reg <= 1'b0;
      word_reg <= 16'h0000;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end else if (i_clk_en) begin
      state_reg <= state_next;
      qtr_reg <= qtr_next;
      phase_reg <= phase_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      remain_reg <= remain_next;
      addr_reg <= addr_next;
      str_reg <= str_next;
      scl_reg <= scl_next;
      oe_reg <= oe_next;
      hs_pend_reg <= hs_pend_next;
      str_en_reg <= str_en_next;
      lo_reg <= lo_next;
      ack_reg <= ack_next;
      busy_reg <= busy_next;
      valid_reg <= valid_next;
      nack_reg <= nack_next;
      word_reg <= word_next;
      sda_s1_reg <= link.sda;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  assign link.scl = scl_reg;
  assign link.host_sda_oe = oe_reg;
  assign link.host_sda_o = 1'b0;
  assign o_busy = busy_reg;
  assign o_word = word_reg;
  assign o_word_valid = valid_reg;
  assign o_addr_nack = nack_reg;
endmodule
`default_nettype wire

// ---- adc_link_if.sv ----
// open-drain two-wire link joining host and converter ends
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // wired-and with pull-up
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface
`default_nettype wire

// ---- adc_link_map.svh ----
// constants for the two-wire converter read link
`ifndef ADC_LINK_MAP_SVH
`define ADC_LINK_MAP_SVH

`define ADC_DEV_ADDR        7'h2A
`define ADC_READ_BIT        1'h1
`define ADC_MASTER_CODE     8'h08
`define ADC_MASTER_CODE_TOP 5'h01
`define ADC_RESULT_BITS     12
`define ADC_BYTE_BITS       4'h8
`define ADC_LEAD_ZEROS      2'h0
`define ADC_CHAN_EN_RST     4'hF
`define ADC_CORE_PERIOD_NS  100
`define ADC_ACQ_TIME_NS     600
`define ADC_ACQ_CYCLES      ((`ADC_ACQ_TIME_NS + `ADC_CORE_PERIOD_NS - 1) / `ADC_CORE_PERIOD_NS)
`define ADC_STRETCH_TIME_NS 2000
`define ADC_STRETCH_CYCLES  ((`ADC_STRETCH_TIME_NS + `ADC_CORE_PERIOD_NS - 1) / `ADC_CORE_PERIOD_NS)
`define ADC_SCL_QTR_CYCLES  4

`endif

// ---- adc_link_pkg.sv ----
// types shared by both ends of the converter read link
`default_nettype none
package adc_link_pkg;
  typedef logic [1:0]  channel_t;
  typedef logic [15:0] result_word_t;

  typedef enum logic [1:0] {
    DEV_IDLE    = 2'h0,
    DEV_ADDR    = 2'h1,
    DEV_READ_HI = 2'h2,
    DEV_READ_LO = 2'h3
  } dev_state_e;

  typedef enum logic [2:0] {
    H_IDLE    = 3'h0,
    H_START   = 3'h1,
    H_SEND    = 3'h2,
    H_RECV    = 3'h3,
    H_STRETCH = 3'h4,
    H_STOP    = 3'h5
  } host_state_e;
endpackage
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench joining host and converter ends
`timescale 1ns/1ps
`include "adc_link_map.svh"
`default_nettype none
module testbench;
  import adc_link_pkg::*;
  logic         i_core_clk = 1'b0;
  logic         i_reset    = 1'b1;
  logic         start = 1'b0, hs = 1'b0, st = 1'b0, res_vld = 1'b0, load = 1'b0, first = 1'b1;
  logic [6:0]   addr  = 7'h00;
  logic [7:0]   cnt   = 8'h01;
  logic [11:0]  res   = 12'h000;
  logic [3:0]   mask  = 4'hF;
  logic [3:0]   masks [5] = '{4'hF, 4'h1, 4'h5, 4'hA, 4'h8};
  logic         busy, wvld, anack, shut, hsf, acq, cst;
  result_word_t word;
  result_word_t latest = 16'h0000;
  result_word_t q [$];
  channel_t     chan;
  channel_t     ch = 2'h0;
  int           err_count = 0, checked = 0, cyc = 0, acq_n = 0;

  always #50 i_core_clk = ~i_core_clk;

  adc_link_if link_bus ();
  adc_link_host u_adc_link_host (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_clk_en(1'b1),
    .link(link_bus), .i_start(start), .i_address(addr), .i_count(cnt), .i_high_speed(hs),
    .i_stretch(st), .o_busy(busy), .o_word(word), .o_word_valid(wvld), .o_addr_nack(anack));
  adc_link_device u_adc_link_device (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_clk_en(1'b1),
    .link(link_bus), .i_result(res), .i_result_valid(res_vld), .i_channel_enable(mask),
    .i_channel_load(load), .o_shutdown(shut), .o_high_speed(hsf), .o_acquire(acq),
    .o_convert_start(cst), .o_channel(chan));
  adc_link_asserts u_adc_link_asserts (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_scl(link_bus.scl), .i_host_sda_o(link_bus.host_sda_o), .i_host_sda_oe(link_bus.host_sda_oe),
    .i_dev_sda_o(link_bus.dev_sda_o), .i_dev_sda_oe(link_bus.dev_sda_oe), .i_sda(link_bus.sda));

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (exp !== got) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // next enabled channel, ascending and wrapping; first wake starts at the lowest
  function automatic channel_t nxt(logic [3:0] m, channel_t p, logic f);
    channel_t c;
    c = f ? 2'h3 : p;
    for (int i = 0; i < 4; i++) begin
      c = c + 2'h1;
      if (m[c]) return c;
    end
    return p;
  endfunction

  // converter stand-in, notes each expected word; the word sent lags one conversion
  always @(posedge i_core_clk) begin
    logic [11:0] r;
    cyc <= cyc + 1;
    acq_n <= acq ? acq_n + 1 : 0;
    res_vld <= cst;
    if (cst === 1'b1) begin
      ch = nxt(mask, ch, first);
      first = 1'b0;
      check("channel", {14'h0, ch}, {14'h0, chan});
      check("acquire", 16'(`ADC_ACQ_CYCLES), 16'(acq_n));
      q.push_back(latest);
      r = 12'($urandom);
      res <= r;
      latest = {`ADC_LEAD_ZEROS, ch, r};
    end
    if (cyc >= 40000) begin
      err_count++;
      stop_test();
    end
  end

  // result monitor: oldest note against each delivered word
  always @(posedge i_core_clk) begin
    if (wvld === 1'b1) begin
      if (q.size() == 0) check("extra word", 16'hFFFF, word);
      else check("word", q.pop_front(), word);
    end
  end

  task automatic run(logic [6:0] a, logic [7:0] n, logic h, logic nak);
    logic hs_seen, awake, nk;
    hs_seen = 1'b0;
    awake = 1'b0;
    nk = 1'b0;
    first = 1'b1;
    @(posedge i_core_clk);
    addr <= a;
    cnt <= n;
    hs <= h;
    st <= 1'($urandom);
    start <= 1'b1;
    @(posedge i_core_clk);
    start <= 1'b0;
    #1;
    while (busy === 1'b1) begin
      @(posedge i_core_clk);
      #1;
      hs_seen |= hsf;
      awake |= !shut;
      nk |= anack;
    end
    repeat (6) @(posedge i_core_clk);
    #1;
    check("shutdown", 16'h1, {15'h0, shut});
    check("high speed", 16'h0, {15'h0, hsf});
    check("hs seen", {15'h0, h & !nak}, {15'h0, hs_seen});
    check("awake", {15'h0, !nak}, {15'h0, awake});
    check("addr nack", {15'h0, nak}, {15'h0, nk});
    check("pending", 16'h0, 16'(q.size()));
  endtask

  initial begin
    void'($urandom(34751));
    repeat (5) @(posedge i_core_clk);
    i_reset <= 1'b0;
    foreach (masks[i]) begin
      @(posedge i_core_clk);
      mask <= masks[i];
      // first pass relies on the all-enabled default
      load <= (i != 0);
      @(posedge i_core_clk);
      load <= 1'b0;
      run(`ADC_DEV_ADDR, 8'(1 + $urandom % 4), 1'(i), 1'b0);
    end
    run(7'h15, 8'h02, 1'b0, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
